// ===== dv/ext_cpu.sv
module ext_cpu (
  input wire logic i_clk,
  input wire logic [7:0] i_dout,
  input wire logic [7:0] i_oe,
  output logic [2:0] o_ctrl_n,
  output logic [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] d = 8'hA5;
  logic en = 1'b0;
  initial o_ctrl_n = 3'h7;
  // device drive wins; a released line shows the inverse, not a stale byte
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pins[i] = i_oe[i] ? i_dout[i] : (en ? d[i] : ~d[i]);
    end
  end
  // plain drive of the data lines, used in port mode
  task automatic put(input logic [7:0] b);
    d <= b;
    en <= 1'b1;
  endtask
  // data held past the strobe so the sync stages see it steady
  task automatic wr(input logic [7:0] b);
    d <= b;
    en <= 1'b1;
    o_ctrl_n <= 3'h1;
    repeat (4) @(posedge i_clk);
    o_ctrl_n <= 3'h7;
    repeat (4) @(posedge i_clk);
    en <= 1'b0;
  endtask
  task automatic rd(output logic [7:0] b);
    o_ctrl_n <= 3'h2;
    repeat (6) @(posedge i_clk);
    b = o_pins;
    o_ctrl_n <= 3'h7;
    repeat (5) @(posedge i_clk);
  endtask
  task automatic hold(input logic [2:0] c, input int n);
    o_ctrl_n <= c;
    repeat (n) @(posedge i_clk);
    o_ctrl_n <= 3'h7;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ===== dv/port_de_slave_port_control_tb.sv
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module port_de_slave_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DS = psp_pkg::OFS_CTRL_DS;
  logic clk, rst_b, psel, pen, pwr, prdy, pslverr;
  logic [7:0] paddr, dout, doe, dpin, x, b1, b3, dd, dl;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] cout, coe, cpin, ectl, r, l, a;
  logic [32:0] q[$];
  logic [32:0] e;
  int failures = 0;
  int num_checks = 0;
  assign cpin = (coe & cout) | (~coe & ectl);
  port_de_slave_port_control u_dut (.I_CORE_CLK(clk), .I_RST_B(rst_b),
    .i_PSEL(psel), .i_PENABLE(pen), .i_PWRITE(pwr), .i_PADDR(paddr),
    .i_PWDATA(pwdata), .i_PSTRB(pstrb), .o_PRDATA(prdata),
    .o_PREADY(prdy), .o_PSLVERR(pslverr), .i_DATA_PIN(dpin),
    .o_DATA_PIN(dout), .o_DATA_OE(doe), .i_CTRL_PIN(cpin),
    .o_CTRL_PIN(cout), .o_CTRL_OE(coe));
  ext_cpu u_ext (.i_clk(clk), .i_dout(dout), .i_oe(doe), .o_ctrl_n(ectl),
    .o_pins(dpin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // read results are matched against the oldest note
  always @(posedge clk) begin
    if (prdy === 1'b1 && pwr === 1'b0) begin
      e = q.pop_front();
      `CHK("prdata", e, {pslverr, prdata})
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [32:0] ex);
    int n;
    if (!w) q.push_back(ex);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end else begin
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b0, ad, 32'h0, {1'b0, d});
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    {psel, pen, pwr, paddr, pwdata} = '0;
    pstrb = 4'hF;
    x = 8'($urandom(60));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(psp_pkg::OFS_DATA_DIR, 32'hFF);
    rd(DS, 32'h07);
    rd(psp_pkg::OFS_ANALOG, 32'h07);
    rd(psp_pkg::OFS_CTRL_PINS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0}); // unmapped word
    $display("test reset done");
    wr(psp_pkg::OFS_ANALOG, 32'h0);
    repeat (4) begin
      r = 3'($urandom);
      l = 3'($urandom);
      wr(DS, {24'h0, 5'h1D, r}); // flag bits and bit 3 must not stick
      wr(psp_pkg::OFS_CTRL_PINS, {29'h0, l});
      rd(DS, {29'h0, r});
      rd(psp_pkg::OFS_CTRL_LATCH, {29'h0, l});
      rd(psp_pkg::OFS_CTRL_PINS, {29'h0, l | r});
      `CHK("ctrl_oe", ~r, coe)
    end
    pstrb <= 4'hE;
    wr(psp_pkg::OFS_CTRL_LATCH, {29'h0, ~l}); // lane off, write dropped
    pstrb <= 4'hF;
    rd(psp_pkg::OFS_CTRL_LATCH, {29'h0, l});
    a = 3'($urandom);
    wr(psp_pkg::OFS_ANALOG, {29'h0, a});
    rd(psp_pkg::OFS_CTRL_PINS, {29'h0, (l | r) & ~a});
    `CHK("ctrl_oe", ~r, coe)
    $display("test ctrl done");
    repeat (3) begin
      x = 8'($urandom);
      dd = 8'($urandom);
      dl = 8'($urandom);
      u_ext.put(x);
      wr(psp_pkg::OFS_DATA_DIR, {24'h0, dd});
      wr(psp_pkg::OFS_DATA_LATCH, {24'h0, dl});
      repeat (4) @(posedge clk);
      rd(psp_pkg::OFS_DATA_PINS, {24'h0, (dl & ~dd) | (x & dd)});
      rd(psp_pkg::OFS_DATA_LATCH, {24'h0, dl});
    end
    $display("test data done");
    wr(psp_pkg::OFS_ANALOG, 32'h0);
    wr(DS, 32'h07);
    wr(DS, 32'h17);
    b1 = 8'($urandom);
    u_ext.wr(b1);
    rd(DS, 32'h97);
    u_ext.wr(~b1);
    rd(DS, 32'hB7);
    rd(psp_pkg::OFS_DATA_PINS, {24'h0, b1});
    rd(DS, 32'h37);
    wr(DS, 32'h37);
    rd(DS, 32'h37);
    wr(DS, 32'h17);
    rd(DS, 32'h17);
    b3 = 8'($urandom);
    wr(psp_pkg::OFS_DATA_PINS, {24'h0, b3});
    rd(DS, 32'h57);
    fork
      u_ext.hold(3'h6, 8);
      begin
        repeat (7) @(posedge clk);
        `CHK("data_oe", 8'h00, doe)
      end
    join
    u_ext.rd(x);
    `CHK("ext_rd", b3, x)
    rd(DS, 32'h17);
    $display("test slave done");
    report_and_stop();
  end
endmodule

// ===== dv/psp_checker.sv
module psp_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic i_PSEL,
  input wire logic i_PENABLE,
  input wire logic i_PWRITE,
  input wire logic [7:0] i_PADDR,
  input wire logic [31:0] i_PWDATA,
  input wire logic [3:0] i_PSTRB,
  input wire logic [31:0] o_PRDATA,
  input wire logic o_PREADY,
  input wire logic [7:0] o_DATA_OE,
  input wire logic [2:0] i_CTRL_PIN,
  input wire logic [2:0] o_CTRL_PIN,
  input wire logic [2:0] o_CTRL_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ds_r;
  logic [2:0] lat_r;
  logic [2:0] an_r;
  logic [7:0] dd_r;
  logic wr_ok;
  logic rd_ok;
  // mirror of software state, moved on the completion edge only
  assign wr_ok = i_PSEL && i_PENABLE && o_PREADY && i_PWRITE && i_PSTRB[0];
  assign rd_ok = o_PREADY && !i_PWRITE;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ds_r <= 5'h07;
      lat_r <= 3'h0;
      an_r <= 3'h7;
      dd_r <= 8'hFF;
    end else if (wr_ok) begin
      if (i_PADDR == psp_pkg::OFS_CTRL_DS) begin
        ds_r <= {i_PWDATA[4], 1'b0, i_PWDATA[2:0]};
      end
      if (i_PADDR == psp_pkg::OFS_CTRL_LATCH ||
          i_PADDR == psp_pkg::OFS_CTRL_PINS) begin
        lat_r <= i_PWDATA[2:0];
      end
      if (i_PADDR == psp_pkg::OFS_ANALOG) begin
        an_r <= i_PWDATA[2:0];
      end
      if (i_PADDR == psp_pkg::OFS_DATA_DIR) begin
        dd_r <= i_PWDATA[7:0];
      end
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  // outputs are registered, so compare only once the mirror has settled
  property p_ctrl_oe;
    $stable(ds_r) |-> o_CTRL_OE == (ds_r[4] ? 3'h0 : ~ds_r[2:0]);
  endproperty
  a_ctrl_oe: assert property (p_ctrl_oe)
    else $error("control pin enable wrong");
  property p_ctrl_pin;
    $stable(lat_r) |-> o_CTRL_PIN == lat_r;
  endproperty
  a_ctrl_pin: assert property (p_ctrl_pin)
    else $error("control pin drive wrong");
  property p_data_oe;
    $stable(dd_r) && $stable(ds_r) && !ds_r[4] |-> o_DATA_OE == ~dd_r;
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data pin enable wrong");
  property p_lat_rd;
    rd_ok && i_PADDR == psp_pkg::OFS_CTRL_LATCH |-> o_PRDATA == {29'h0, lat_r};
  endproperty
  a_lat_rd: assert property (p_lat_rd)
    else $error("latch read wrong");
  property p_ds_rd;
    rd_ok && i_PADDR == psp_pkg::OFS_CTRL_DS
      |-> o_PRDATA[4:0] == ds_r && o_PRDATA[31:8] == 24'h0;
  endproperty
  a_ds_rd: assert property (p_ds_rd)
    else $error("status read wrong");
  property p_an_rd;
    rd_ok && i_PADDR == psp_pkg::OFS_CTRL_PINS && an_r == 3'h7
      |-> o_PRDATA == 32'h0;
  endproperty
  a_an_rd: assert property (p_an_rd)
    else $error("analog pins not zero");
  property p_idle_oe;
    (ds_r[4] && i_CTRL_PIN == 3'h7) [*6] |-> o_DATA_OE == 8'h00;
  endproperty
  a_idle_oe: assert property (p_idle_oe)
    else $error("data driven without read");
  property p_desel;
    (ds_r[4] && i_CTRL_PIN[2]) [*6] |-> o_DATA_OE == 8'h00;
  endproperty
  a_desel: assert property (p_desel)
    else $error("data driven while deselected");
  property p_rd_oe;
    (ds_r[4] && i_CTRL_PIN == 3'h7) ##1 (ds_r[4] && i_CTRL_PIN == 3'h2) [*6]
      |-> o_DATA_OE == 8'hFF;
  endproperty
  a_rd_oe: assert property (p_rd_oe)
    else $error("read not driven");
  c_ext_rd: cover property ($rose(o_DATA_OE[0]) && ds_r[4]);
  c_mode: cover property ($rose(ds_r[4]));
  c_ctrl_drive: cover property (o_CTRL_OE != 3'h0);
endmodule

bind port_de_slave_port_control psp_checker u_chk (
  .I_CORE_CLK, .I_RST_B, .i_PSEL, .i_PENABLE, .i_PWRITE, .i_PADDR,
  .i_PWDATA, .i_PSTRB, .o_PRDATA, .o_PREADY, .o_DATA_OE, .i_CTRL_PIN,
  .o_CTRL_PIN, .o_CTRL_OE
);

// ===== logic/pin_sync.sv
// two-flop synchroniser, one pair per bit
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      // meta_r feeds sync_r only
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r[b] <= RST_VAL[b];
          sync_r[b] <= RST_VAL[b];
        end else begin
          meta_r[b] <= i_async[b];
          sync_r[b] <= meta_r[b];
        end
      end
    end
  endgenerate

  assign o_sync = sync_r;

endmodule

// ===== logic/port_de_slave_port_control.sv
// Contract
// - three control pins, each with direction bit
// - direction 1 makes control pin an input
// - direction 0 drives pin from its latch
// - latch readable, returns latch not pins
// - analog-selected control pin reads as zero
// - direction still rules pins in analog use
// - reset makes all control pins analog
// - data pins are gpio or slave byte
// - direction register also holds slave-port bits
// - low read strobe with select reads data
// - low write strobe with select writes data
// - chip select low selects, high deselects
// - bit6 set until external side reads output
// - bit5 set on overrun, software clears it
// - bit3 unimplemented, reads zero
// - mode bit turns control pins into strobes
// - write starts at first select and strobe low
// - read starts at first select and strobe low
module port_de_slave_port_control (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic i_PSEL,
  input wire logic i_PENABLE,
  input wire logic i_PWRITE,
  input wire logic [psp_pkg::ADDR_W-1:0] i_PADDR,
  input wire logic [psp_pkg::WORD_W-1:0] i_PWDATA,
  input wire logic [3:0] i_PSTRB,
  output logic [psp_pkg::WORD_W-1:0] o_PRDATA,
  output logic o_PREADY,
  output logic o_PSLVERR,
  input wire logic [psp_pkg::DATA_W-1:0] i_DATA_PIN,
  output logic [psp_pkg::DATA_W-1:0] o_DATA_PIN,
  output logic [psp_pkg::DATA_W-1:0] o_DATA_OE,
  input wire logic [psp_pkg::CTRL_W-1:0] i_CTRL_PIN,
  output logic [psp_pkg::CTRL_W-1:0] o_CTRL_PIN,
  output logic [psp_pkg::CTRL_W-1:0] o_CTRL_OE
);

  // data port state
  logic [psp_pkg::DATA_W-1:0] latch_d_r;
  logic [psp_pkg::DATA_W-1:0] dir_d_r;
  logic [psp_pkg::DATA_W-1:0] inbuf_r;

  // control port and slave-port status
  logic [psp_pkg::CTRL_W-1:0] dir_e_r;
  logic [psp_pkg::CTRL_W-1:0] latch_e_r;
  logic [psp_pkg::CTRL_W-1:0] analog_r;
  logic ibf_r;
  logic obf_r;
  logic input_overrun_flag_r;
  logic mode_r;

  // bus response
  logic pready_r;
  logic pslverr_r;
  logic [psp_pkg::WORD_W-1:0] prdata_r;

  // pin outputs
  logic [psp_pkg::DATA_W-1:0] data_out_r;
  logic [psp_pkg::DATA_W-1:0] data_oe_r;
  logic [psp_pkg::CTRL_W-1:0] ctrl_out_r;
  logic [psp_pkg::CTRL_W-1:0] ctrl_oe_r;

  // synchronised pins and slave-port events
  logic [psp_pkg::DATA_W-1:0] data_sync;
  logic [psp_pkg::CTRL_W-1:0] ctrl_sync;
  psp_pkg::strobe_t strobe;
  psp_pkg::psp_evt_t evt;

  // bus decode
  logic apb_done;
  logic wr_en;
  logic rd_done;
  logic lane0;
  logic sel_data_pins;
  logic sel_data_latch;
  logic sel_data_dir;
  logic sel_ctrl_ds;
  logic sel_ctrl_latch;
  logic sel_ctrl_pins;
  logic sel_analog;
  logic mapped;
  logic [psp_pkg::WORD_W-1:0] rd_word;
  logic [psp_pkg::DATA_W-1:0] status_byte;
  logic [psp_pkg::CTRL_W-1:0] ctrl_read;
  logic cpu_data_write;

  // both pin groups are asynchronous to the core clock; two flops per
  // bit add two cycles to every pin read and strobe, which the external
  // bus covers by holding its data steady that long
  pin_sync #(
    .WIDTH(psp_pkg::DATA_W),
    .RST_VAL(psp_pkg::RST_DATA_LATCH)
  ) u_data_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_async(i_DATA_PIN),
    .o_sync(data_sync)
  );

  // control pins idle high so strobes look inactive out of reset
  pin_sync #(
    .WIDTH(psp_pkg::CTRL_W),
    .RST_VAL(psp_pkg::RST_CTRL_IDLE)
  ) u_ctrl_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_async(i_CTRL_PIN),
    .o_sync(ctrl_sync)
  );

  // control pins become the strobes while the mode bit is set; while
  // it is clear the detector is held off, so port traffic starts nothing
  assign strobe.cs_n = ctrl_sync[psp_pkg::PIN_CS];
  assign strobe.wr_n = ctrl_sync[psp_pkg::PIN_WR];
  assign strobe.rd_n = ctrl_sync[psp_pkg::PIN_RD];

  // one edge detector per strobe kind; each start event lasts one cycle, rd_active lasts as long as the read
  psp_strobe_detect u_detect (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_enable(mode_r),
    .i_strobe(strobe),
    .o_evt(evt)
  );

  // one wait state: pready rises at the end of the first access cycle, the
  // transfer completes at the edge that samples it high; writes and
  // read side effects act on that edge only. a write whose low byte
  // lane is off is dropped without an error, since every register
  // lives in that lane
  assign apb_done = i_PSEL & i_PENABLE & pready_r;
  assign lane0 = i_PSTRB[0];
  assign wr_en = apb_done & i_PWRITE & lane0 & mapped;
  assign rd_done = apb_done & ~i_PWRITE;

  // address decode; only whole word addresses match, so an unaligned
  // address falls through to the error response
  assign sel_data_pins = (i_PADDR == psp_pkg::OFS_DATA_PINS);
  assign sel_data_latch = (i_PADDR == psp_pkg::OFS_DATA_LATCH);
  assign sel_data_dir = (i_PADDR == psp_pkg::OFS_DATA_DIR);
  assign sel_ctrl_ds = (i_PADDR == psp_pkg::OFS_CTRL_DS);
  assign sel_ctrl_latch = (i_PADDR == psp_pkg::OFS_CTRL_LATCH);
  assign sel_ctrl_pins = (i_PADDR == psp_pkg::OFS_CTRL_PINS);
  assign sel_analog = (i_PADDR == psp_pkg::OFS_ANALOG);
  assign mapped = sel_data_pins | sel_data_latch | sel_data_dir |
                  sel_ctrl_ds | sel_ctrl_latch | sel_ctrl_pins |
                  sel_analog;

  // a cpu write to the data port lands in the output latch
  assign cpu_data_write = wr_en & (sel_data_pins | sel_data_latch);

  // status byte; bit 3 is left as zero. the flags share the word with
  // the direction bits so one read shows both; the read-only flags
  // are never loaded from the bus, so writes to them have no effect
  always_comb begin
    status_byte = '0;
    status_byte[psp_pkg::BIT_IBF] = ibf_r;
    status_byte[psp_pkg::BIT_OBF] = obf_r;
    status_byte[psp_pkg::BIT_INPUT_OVERRUN_FLAG] = input_overrun_flag_r;
    status_byte[psp_pkg::BIT_MODE] = mode_r;
    status_byte[psp_pkg::BIT_DIR_MSB:psp_pkg::BIT_DIR_LSB] = dir_e_r;
  end

  // analog-selected pins read as zero
  assign ctrl_read = ctrl_sync & ~analog_r;

  // read mux; narrow registers sit in the low bits and the rest read
  // zero. latch words return the latch rather than the pins, so a
  // read-modify-write never copies an input level into a latch
  always_comb begin
    rd_word = '0;
    if (sel_data_pins) begin
      // slave mode returns the received byte, else the pin levels
      rd_word[psp_pkg::DATA_W-1:0] = mode_r ? inbuf_r : data_sync;
    end else if (sel_data_latch) begin
      rd_word[psp_pkg::DATA_W-1:0] = latch_d_r;
    end else if (sel_data_dir) begin
      rd_word[psp_pkg::DATA_W-1:0] = dir_d_r;
    end else if (sel_ctrl_ds) begin
      rd_word[psp_pkg::DATA_W-1:0] = status_byte;
    end else if (sel_ctrl_latch) begin
      rd_word[psp_pkg::CTRL_W-1:0] = latch_e_r;
    end else if (sel_ctrl_pins) begin
      rd_word[psp_pkg::CTRL_W-1:0] = ctrl_read;
    end else if (sel_analog) begin
      rd_word[psp_pkg::CTRL_W-1:0] = analog_r;
    end
  end

  // apb handshake and registered read data; the word is captured in
  // the first access cycle and shown for one cycle with pready, which
  // keeps the read mux off the bus's output path at the cost of a
  // fixed wait state on every transfer
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (i_PSEL & i_PENABLE & ~pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r <= i_PWRITE ? '0 : rd_word;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
  end

  // data port latch and direction
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      latch_d_r <= psp_pkg::RST_DATA_LATCH;
      dir_d_r <= psp_pkg::RST_DATA_DIR;
    end else begin
      if (cpu_data_write) begin
        latch_d_r <= i_PWDATA[psp_pkg::DATA_W-1:0];
      end
      if (wr_en & sel_data_dir) begin
        dir_d_r <= i_PWDATA[psp_pkg::DATA_W-1:0];
      end
    end
  end

  // control port latch, direction, mode and analog selection; the
  // direction bits keep their value while the mode bit is set, so
  // clearing it restores the earlier pin setup. software should
  // release the pins before setting the mode, or the port's own drive
  // still in the synchronisers can look like a strobe
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      latch_e_r <= psp_pkg::RST_CTRL_LATCH;
      dir_e_r <= psp_pkg::RST_CTRL_DIR;
      analog_r <= psp_pkg::RST_ANALOG;
      mode_r <= 1'b0;
    end else begin
      if (wr_en & (sel_ctrl_latch | sel_ctrl_pins)) begin
        latch_e_r <= i_PWDATA[psp_pkg::CTRL_W-1:0];
      end
      if (wr_en & sel_ctrl_ds) begin
        dir_e_r <= i_PWDATA[psp_pkg::BIT_DIR_MSB:psp_pkg::BIT_DIR_LSB];
        mode_r <= i_PWDATA[psp_pkg::BIT_MODE];
      end
      if (wr_en & sel_analog) begin
        analog_r <= i_PWDATA[psp_pkg::CTRL_W-1:0];
      end
    end
  end

  // received byte is taken at the start of an external write; an
  // overrun keeps the unread byte rather than losing it silently;
  // the byte passes the same two flops as the strobes, so they line up
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      inbuf_r <= psp_pkg::RST_DATA_LATCH;
    end else if (evt.wr_start & ~ibf_r) begin
      inbuf_r <= data_sync;
    end
  end

  // input word pending: set on receive, cleared by a cpu data read;
  // a receive in the same cycle as that read wins, so a new byte is
  // never reported as already taken
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ibf_r <= 1'b0;
    end else if (evt.wr_start) begin
      ibf_r <= 1'b1;
    end else if (rd_done & sel_data_pins & mode_r) begin
      ibf_r <= 1'b0;
    end
  end

  // output word pending: set by a cpu write in slave mode, cleared
  // when the external side starts its read; a set in the same cycle
  // wins so a fresh word is never reported as taken
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      obf_r <= 1'b0;
    end else if (cpu_data_write & mode_r) begin
      obf_r <= 1'b1;
    end else if (evt.rd_start) begin
      obf_r <= 1'b0;
    end
  end

  // overrun: write while a byte is still unread; software clears it
  // by writing zero to the bit, and a new overrun beats that clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      input_overrun_flag_r <= 1'b0;
    end else if (evt.wr_start & ibf_r) begin
      input_overrun_flag_r <= 1'b1;
    end else if (wr_en & sel_ctrl_ds & ~i_PWDATA[psp_pkg::BIT_INPUT_OVERRUN_FLAG]) begin
      input_overrun_flag_r <= 1'b0;
    end
  end

  // data pin drivers: in slave mode the latch drives only during a
  // selected external read, otherwise each direction bit decides;
  // the drive lingers a few cycles after the strobes rise, since
  // their release has to pass the synchronisers too
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      data_out_r <= psp_pkg::RST_DATA_LATCH;
      data_oe_r <= '0;
    end else begin
      data_out_r <= latch_d_r;
      if (mode_r) begin
        data_oe_r <= {psp_pkg::DATA_W{evt.rd_active}};
      end else begin
        data_oe_r <= ~dir_d_r;
      end
    end
  end

  // control pin drivers; slave mode forces them to inputs since they
  // carry the strobes, analog selection does not override direction;
  // keeping an analog pin an input is left to software
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_out_r <= psp_pkg::RST_CTRL_LATCH;
      ctrl_oe_r <= '0;
    end else begin
      ctrl_out_r <= latch_e_r;
      ctrl_oe_r <= ~dir_e_r & {psp_pkg::CTRL_W{~mode_r}};
    end
  end

  assign o_PRDATA = prdata_r;
  assign o_PREADY = pready_r;
  assign o_PSLVERR = pslverr_r;
  assign o_DATA_PIN = data_out_r;
  assign o_DATA_OE = data_oe_r;
  assign o_CTRL_PIN = ctrl_out_r;
  assign o_CTRL_OE = ctrl_oe_r;

endmodule

// ===== logic/psp_pkg.sv
package psp_pkg;

  // apb word offsets, one aligned word per register
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DATA_PINS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA_LATCH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL_DS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTRL_LATCH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CTRL_PINS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ANALOG = 8'h18;

  // widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned WORD_W = 32;

  // ctrl_port_direction_status field positions
  localparam int unsigned BIT_IBF = 7;
  localparam int unsigned BIT_OBF = 6;
  localparam int unsigned BIT_INPUT_OVERRUN_FLAG = 5;
  localparam int unsigned BIT_MODE = 4;
  localparam int unsigned BIT_DIR_MSB = 2;
  localparam int unsigned BIT_DIR_LSB = 0;

  // control pin roles in slave-port mode
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;

  // reset values
  localparam logic [DATA_W-1:0] RST_DATA_DIR = 8'hFF;
  localparam logic [DATA_W-1:0] RST_DATA_LATCH = 8'h00;
  localparam logic [CTRL_W-1:0] RST_CTRL_DIR = 3'h7;
  localparam logic [CTRL_W-1:0] RST_CTRL_LATCH = 3'h0;
  localparam logic [CTRL_W-1:0] RST_ANALOG = 3'h7;
  localparam logic [CTRL_W-1:0] RST_CTRL_IDLE = 3'h7;

  // slave-port strobes as seen after synchronisation, all active low
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } strobe_t;

  // slave-port events
  typedef struct packed {
    logic wr_start;
    logic rd_start;
    logic rd_active;
  } psp_evt_t;

endpackage

// ===== logic/psp_strobe_detect.sv
// finds the first cycle of a qualified slave-port read or write
module psp_strobe_detect (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire psp_pkg::strobe_t i_strobe,
  output psp_pkg::psp_evt_t o_evt
);

  logic wr_act;
  logic rd_act;
  logic wr_prev_r;
  logic rd_prev_r;

  // qualified strobes: chip select low together with the strobe low
  assign wr_act = i_enable & ~i_strobe.cs_n & ~i_strobe.wr_n;
  assign rd_act = i_enable & ~i_strobe.cs_n & ~i_strobe.rd_n;

  // history for edge detection; a held strobe starts one access only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
    end else begin
      wr_prev_r <= wr_act;
      rd_prev_r <= rd_act;
    end
  end

  assign o_evt.wr_start = wr_act & ~wr_prev_r;
  assign o_evt.rd_start = rd_act & ~rd_prev_r;
  assign o_evt.rd_active = rd_act;

endmodule
